/* include/iopw_consts.vh */
// Constants for the IO pin output and PWM control block.
// Assumes byte addresses on an 8-bit Avalon-MM address bus.
`ifndef IOPW_CONSTS_VH
`define IOPW_CONSTS_VH

// Register byte offsets
`define IOPW_CFG_BASE 8'h00
`define IOPW_GEN0_HI 8'h80
`define IOPW_GEN0_LO 8'h84
`define IOPW_GEN1_HI 8'h88
`define IOPW_GEN1_LO 8'h8C
`define IOPW_STATUS 8'h90

// Pin config word field positions
`define IOPW_F_FUNC_LO 0
`define IOPW_F_DIR 2
`define IOPW_F_OTYPE_LO 3
`define IOPW_F_LEVEL 5
`define IOPW_F_MODE_LO 8
`define IOPW_F_SEL_LO 12
`define IOPW_F_STAT 16

// Pin function codes
`define IOPW_FN_SERIAL 2'h0
`define IOPW_FN_GPIO 2'h1
`define IOPW_FN_DEDIC 2'h2

// Drive type codes
`define IOPW_OT_PUSHPULL 2'h0
`define IOPW_OT_OPENDRAIN 2'h1
`define IOPW_OT_TRISTATE 2'h2

// PWM control codes
`define IOPW_MD_IDLE 3'h0
`define IOPW_MD_STOPLOW 3'h1
`define IOPW_MD_ONESHOT 3'h2
`define IOPW_MD_RUN 3'h3
`define IOPW_MD_STOPHIGH 3'h4

// PWM generator selector codes
`define IOPW_SEL_NONE 2'h0
`define IOPW_SEL_GEN0 2'h1
`define IOPW_SEL_GEN1 2'h2

// Reset values
`define IOPW_PERIOD_RST 16'h0064
`define IOPW_FUNC_RST 2'h0

`endif

/* src/iopw_pwm_gen.v */
// One PWM generator: alternating high and low phases counted in mclk.
// Assumes the period inputs come from registers on the same clock.
`timescale 1ns/10ps
module iopw_pwm_gen #(
   parameter CW = 16
) (
   input wire mclk,
   input wire arst_n,
   input wire active,
   input wire [CW-1:0] high_len,
   input wire [CW-1:0] low_len,
   output reg level,
   output reg rise,
   output reg fall
);

reg [CW-1:0] cnt;
wire [CW-1:0] limit;
wire [CW:0] cnt_inc;

assign limit = level ? high_len : low_len;
assign cnt_inc = {1'b0, cnt} + {{CW{1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////
// Phase counter
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      cnt <= {CW{1'b0}};
      level <= 1'b1;
      rise <= 1'b0;
      fall <= 1'b0;
   end else if (!active) begin
      cnt <= {CW{1'b0}};
      level <= 1'b1;
      rise <= 1'b0;
      fall <= 1'b0;
   end else if (cnt_inc >= {1'b0, limit}) begin
      // Phase ends, swap level
      cnt <= {CW{1'b0}};
      level <= ~level;
      rise <= ~level;
      fall <= level;
   end else begin
      cnt <= cnt_inc[CW-1:0];
      rise <= 1'b0;
      fall <= 1'b0;
   end
end

endmodule // iopw_pwm_gen

/* src/iopw_top.v */
// Multi-function IO pins with two shared PWM generators.
// Assumes an Avalon-MM master on mclk; pins are asynchronous.
`timescale 1ns/10ps
`include "iopw_consts.vh"
module iopw_top #(
   parameter NPIN = 32,
   parameter CW = 16
) (
   input wire mclk,
   input wire arst_n,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire [NPIN-1:0] pin_in,
   output reg [NPIN-1:0] pin_out,
   output reg [NPIN-1:0] pin_oe_n,
   input wire [NPIN-1:0] ser_out,
   input wire [NPIN-1:0] ser_oe,
   output reg [NPIN-1:0] ser_in
);

localparam OS_IDLE = 3'b001;
localparam OS_FIRST = 3'b010;
localparam OS_SECOND = 3'b100;

////////////////////////////////////////////////////////////////////////
// Pin input synchroniser
reg [NPIN-1:0] pin_meta;
reg [NPIN-1:0] pin_sync;

always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      pin_meta <= {NPIN{1'b0}};
      pin_sync <= {NPIN{1'b0}};
   end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
   end
end

////////////////////////////////////////////////////////////////////////
// Bus handshake
wire req;
wire bus_go;
wire wr_go;
wire cfg_area;
wire [4:0] cfg_idx;

assign req = read | write;
assign bus_go = req & ~waitrequest;
assign wr_go = write & ~waitrequest;
assign cfg_area = (address[7] == 1'b0);
assign cfg_idx = address[6:2];

////////////////////////////////////////////////////////////////////////
// Generator period registers
reg [CW-1:0] gen_hi0;
reg [CW-1:0] gen_lo0;
reg [CW-1:0] gen_hi1;
reg [CW-1:0] gen_lo1;

function [CW-1:0] merge16;
   input [CW-1:0] old;
   input [31:0] wd;
   input [3:0] be;
   begin
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[CW-1:8] = wd[CW-1:8];
      end
   end
endfunction

always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      gen_hi0 <= `IOPW_PERIOD_RST;
      gen_lo0 <= `IOPW_PERIOD_RST;
      gen_hi1 <= `IOPW_PERIOD_RST;
      gen_lo1 <= `IOPW_PERIOD_RST;
   end else if (wr_go) begin
      if (address == `IOPW_GEN0_HI) begin
         gen_hi0 <= merge16(gen_hi0, writedata, byteenable);
      end else if (address == `IOPW_GEN0_LO) begin
         gen_lo0 <= merge16(gen_lo0, writedata, byteenable);
      end else if (address == `IOPW_GEN1_HI) begin
         gen_hi1 <= merge16(gen_hi1, writedata, byteenable);
      end else if (address == `IOPW_GEN1_LO) begin
         gen_lo1 <= merge16(gen_lo1, writedata, byteenable);
      end
   end
end

////////////////////////////////////////////////////////////////////////
// The two shared generators
wire [1:0] gen_active;
wire [1:0] gen_level;
wire [1:0] gen_rise;
wire [1:0] gen_fall;
wire [NPIN-1:0] want0;
wire [NPIN-1:0] want1;

assign gen_active[0] = |want0;
assign gen_active[1] = |want1;

iopw_pwm_gen #(
   .CW(CW)
) u_gen0 (
   .mclk(mclk),
   .arst_n(arst_n),
   .active(gen_active[0]),
   .high_len(gen_hi0),
   .low_len(gen_lo0),
   .level(gen_level[0]),
   .rise(gen_rise[0]),
   .fall(gen_fall[0])
);

iopw_pwm_gen #(
   .CW(CW)
) u_gen1 (
   .mclk(mclk),
   .arst_n(arst_n),
   .active(gen_active[1]),
   .high_len(gen_hi1),
   .low_len(gen_lo1),
   .level(gen_level[1]),
   .rise(gen_rise[1]),
   .fall(gen_fall[1])
);

////////////////////////////////////////////////////////////////////////
// Per-pin configuration, PWM control and drive
wire [32*NPIN-1:0] cfg_flat;
wire [NPIN-1:0] next_pin_out;
wire [NPIN-1:0] next_oe_n;
wire [NPIN-1:0] next_stat;

genvar i;
generate
   for (i = 0; i < NPIN; i = i + 1) begin : g_pin
      reg [1:0] func;
      reg dir;
      reg [1:0] otype;
      reg level;
      reg [2:0] mode;
      reg [1:0] sel;
      reg [2:0] os_st;
      reg os_start;
      reg pwm_q;
      reg drv;
      reg out_v;
      reg oe_v;
      wire hit;
      wire pwm_use;
      wire g_lvl;
      wire g_rise;
      wire g_fall;
      wire moving;

      assign hit = wr_go & cfg_area & (cfg_idx == i);
      assign pwm_use = (func == `IOPW_FN_DEDIC) & dir &
         ((sel == `IOPW_SEL_GEN0) | (sel == `IOPW_SEL_GEN1));
      assign g_lvl = (sel == `IOPW_SEL_GEN1) ? gen_level[1] : gen_level[0];
      assign g_rise = (sel == `IOPW_SEL_GEN1) ? gen_rise[1] : gen_rise[0];
      assign g_fall = (sel == `IOPW_SEL_GEN1) ? gen_fall[1] : gen_fall[0];
      assign moving = pwm_use &
         ((mode == `IOPW_MD_RUN) | (mode == `IOPW_MD_ONESHOT));
      assign want0 [i] = moving & (sel == `IOPW_SEL_GEN0);
      assign want1 [i] = moving & (sel == `IOPW_SEL_GEN1);

      // Control state and PWM output level
      always @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            func <= `IOPW_FUNC_RST;
            dir <= 1'b0;
            otype <= `IOPW_OT_PUSHPULL;
            level <= 1'b0;
            mode <= `IOPW_MD_IDLE;
            sel <= `IOPW_SEL_NONE;
            os_st <= OS_IDLE;
            os_start <= 1'b0;
            pwm_q <= 1'b0;
         end else begin
            case (mode)
               `IOPW_MD_STOPLOW: begin
                  pwm_q <= 1'b0;
                  os_st <= OS_IDLE;
               end
               `IOPW_MD_STOPHIGH: begin
                  pwm_q <= 1'b1;
                  os_st <= OS_IDLE;
               end
               `IOPW_MD_RUN: begin
                  if (pwm_use) begin
                     pwm_q <= g_lvl;
                  end
                  os_st <= OS_IDLE;
               end
               `IOPW_MD_ONESHOT: begin
                  if (!pwm_use) begin
                     os_st <= OS_IDLE;
                  end else begin
                     case (os_st)
                        OS_IDLE: begin
                           os_start <= pwm_q;
                           os_st <= OS_FIRST;
                        end
                        OS_FIRST: begin
                           if (os_start ? g_fall : g_rise) begin
                              pwm_q <= ~os_start;
                              os_st <= OS_SECOND;
                           end
                        end
                        OS_SECOND: begin
                           if (os_start ? g_rise : g_fall) begin
                              pwm_q <= os_start;
                              os_st <= OS_IDLE;
                              mode <= `IOPW_MD_IDLE;
                           end
                        end
                        default: begin
                           os_st <= OS_IDLE;
                        end
                     endcase
                  end
               end
               default: begin
                  os_st <= OS_IDLE;
               end
            endcase
            // Software write to byte lanes wins over hardware update
            if (hit && byteenable[0]) begin
               func <= writedata[`IOPW_F_FUNC_LO+1:`IOPW_F_FUNC_LO];
               dir <= writedata[`IOPW_F_DIR];
               otype <= writedata[`IOPW_F_OTYPE_LO+1:`IOPW_F_OTYPE_LO];
               level <= writedata[`IOPW_F_LEVEL];
            end
            if (hit && byteenable[1]) begin
               mode <= writedata[`IOPW_F_MODE_LO+2:`IOPW_F_MODE_LO];
               sel <= writedata[`IOPW_F_SEL_LO+1:`IOPW_F_SEL_LO];
               os_st <= OS_IDLE;
            end
         end
      end

      // Pin drive from function, direction and type
      always @* begin
         drv = pwm_use ? pwm_q : level;
         out_v = 1'b0;
         oe_v = 1'b1;
         if (func == `IOPW_FN_SERIAL) begin
            out_v = ser_out[i];
            oe_v = ~ser_oe[i];
         end else if (dir) begin
            if (otype == `IOPW_OT_PUSHPULL) begin
               out_v = drv;
               oe_v = 1'b0;
            end else if (otype == `IOPW_OT_OPENDRAIN) begin
               out_v = 1'b0;
               oe_v = drv;
            end else begin
               out_v = 1'b1;
               oe_v = ~drv;
            end
         end
      end

      assign next_pin_out[i] = out_v;
      assign next_oe_n[i] = oe_v;
      assign next_stat[i] = (func != `IOPW_FN_SERIAL) & ~pwm_use &
         pin_sync[i];
      assign cfg_flat[32*i +: 32] = {15'h0000, next_stat[i], 2'h0, sel,
         1'b0, mode, 2'h0, level, otype, dir, func};
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// Status word
wire [31:0] stat_word;

generate
   if (NPIN < 32) begin : g_stat_pad
      assign stat_word = {{(32-NPIN){1'b0}}, next_stat};
   end else begin : g_stat_full
      assign stat_word = next_stat[31:0];
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// Read decode
reg [31:0] next_readdata;

always @* begin
   next_readdata = 32'h00000000;
   if (cfg_area) begin
      if (cfg_idx < NPIN) begin
         next_readdata = cfg_flat[32*cfg_idx +: 32];
      end
   end else if (address == `IOPW_GEN0_HI) begin
      next_readdata = {{(32-CW){1'b0}}, gen_hi0};
   end else if (address == `IOPW_GEN0_LO) begin
      next_readdata = {{(32-CW){1'b0}}, gen_lo0};
   end else if (address == `IOPW_GEN1_HI) begin
      next_readdata = {{(32-CW){1'b0}}, gen_hi1};
   end else if (address == `IOPW_GEN1_LO) begin
      next_readdata = {{(32-CW){1'b0}}, gen_lo1};
   end else if (address == `IOPW_STATUS) begin
      next_readdata = stat_word;
   end
end

////////////////////////////////////////////////////////////////////////
// Bus answer: one wait cycle per access
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
   end else if (bus_go) begin
      waitrequest <= 1'b1;
   end else if (req) begin
      waitrequest <= 1'b0;
      if (read) begin
         readdata <= next_readdata;
      end
   end else begin
      waitrequest <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////
// Registered pin outputs
always @(posedge mclk or negedge arst_n) begin
   if (!arst_n) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe_n <= {NPIN{1'b1}};
      ser_in <= {NPIN{1'b0}};
   end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_oe_n;
      ser_in <= pin_sync;
   end
end

endmodule // iopw_top

/* bench/iopw_monitor.sv */
// Checker for bus handshake and pin 0 drive of the IO pin block.
// Assumes bind to iopw_top; pin 0 config is tracked from bus writes.
`timescale 1ns/10ps
module iopw_chk #(
   parameter NPIN = 32
) (
   input wire mclk,
   input wire arst_n,
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire [NPIN-1:0] pin_in,
   input wire [NPIN-1:0] pin_out,
   input wire [NPIN-1:0] pin_oe_n,
   input wire [NPIN-1:0] ser_out,
   input wire [NPIN-1:0] ser_oe
);
   reg [13:0] cfg;
   reg [13:0] pcfg;
   reg [13:0] ppcfg;
   reg [3:0] hist;
   wire stab = cfg == pcfg && pcfg == ppcfg;
   wire [1:0] ty = cfg[4:3];
   wire lv = cfg[5];
   wire [2:0] md = cfg[10:8];
   wire sel = cfg[13:12] == 2'h1 || cfg[13:12] == 2'h2;
   wire pwm = cfg[1:0] == 2'h2 && cfg[2] && sel;
   wire gp = stab && cfg[1:0] != 2'h0 && !pwm;
   wire eo = ty == 2'h0 ? lv : ty != 2'h1;
   wire eoe = ty == 2'h0 ? 1'b0 : ty == 2'h1 ? lv : !lv;
   //////////////////////////////
   // Shadow of pin 0 config
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg <= 14'h0;
         pcfg <= 14'h0;
         ppcfg <= 14'h0;
         hist <= 4'h0;
      end else begin
         pcfg <= cfg;
         ppcfg <= pcfg;
         hist <= {hist[2:0], pin_in[0]};
         if (write && !waitrequest && address == 8'h00) begin
            if (byteenable[0])
               cfg[5:0] <= writedata[5:0];
            if (byteenable[1])
               cfg[13:8] <= writedata[13:8];
         end
      end
   end
   //////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_ANSWER: assert property (
      (read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered");
   AST_ONEWAIT: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   AST_NOREQ: assert property (!read && !write |=> waitrequest)
      else $error("answer without request");
   AST_SER: assert property (stab && cfg[1:0] == 2'h0 && $past(arst_n)
      |-> pin_out[0] == $past(ser_out[0]) && pin_oe_n[0] == !$past(ser_oe[0]))
      else $error("serial pass-through wrong");
   AST_DIRIN: assert property (
      gp && !cfg[2] |-> pin_oe_n[0] && !pin_out[0])
      else $error("input pin driven");
   AST_GPIO: assert property (
      gp && cfg[2] |-> pin_out[0] == eo && pin_oe_n[0] == eoe)
      else $error("output drive wrong");
   AST_STOPLO: assert property (
      stab && pwm && md == 3'h1 && ty == 2'h0 |-> !pin_out[0] && !pin_oe_n[0])
      else $error("stop-low not low");
   AST_STOPHI: assert property (
      stab && pwm && md == 3'h4 && ty == 2'h0 |-> pin_out[0] && !pin_oe_n[0])
      else $error("stop-high not high");
   AST_STAT: assert property (
      read && !waitrequest && address == 8'h90 && gp && (&hist || ~|hist)
      |-> readdata[0] == hist[0])
      else $error("status bit wrong");
endmodule // iopw_chk

/* bench/iopw_load.sv */
// External circuit on the pins: pull-up loads and an optional driver.
// Assumes active-low output enables; block drive wins over the driver.
`timescale 1ns/10ps
module iopw_load #(
   parameter NPIN = 4
) (
   input wire [NPIN-1:0] pin_out,
   input wire [NPIN-1:0] pin_oe_n,
   input wire [NPIN-1:0] ext_en,
   input wire [NPIN-1:0] ext_val,
   output wire [NPIN-1:0] pin_lvl
);
   // Undriven pins float up to the pull-up
   assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ~ext_en)
      | (pin_oe_n & ext_en & ext_val);
endmodule // iopw_load

/* bench/tb.sv */
// Testbench for the IO pin block: serial cases, table cases, status cases, then PWM and reset cases.
// Assumes four pins, the load model and the bound checker.
`timescale 1ns/10ps
`include "iopw_consts.vh"
module tb;
   localparam [79:0] ROWS = {10'h005, 10'h014, 10'h096, 10'h034,
      10'h0B5, 10'h057, 10'h0D6, 10'h0DA};
   reg mclk = 1'b0;
   reg arst_n = 1'b0;
   reg [7:0] address = 8'h00;
   reg read = 1'b0;
   reg write = 1'b0;
   reg [31:0] writedata = 32'h0;
   reg [3:0] byteenable = 4'hF;
   reg [3:0] ser_out = 4'hA;
   reg [3:0] ser_oe = 4'h3;
   reg [3:0] ext_en = 4'h0;
   reg [3:0] ext_val = 4'h0;
   wire [31:0] readdata;
   wire waitrequest;
   wire [3:0] pin_out;
   wire [3:0] pin_oe_n;
   wire [3:0] pin_lvl;
   wire [3:0] ser_in;
   reg [31:0] rdv;
   reg lv;
   integer mismatches = 0;
   integer n_compared = 0;
   integer i;
   integer h;
   integer h1;
   always #2.5 mclk = ~mclk;
   iopw_top #(.NPIN(4), .CW(16)) i_iopw_top (.mclk(mclk), .arst_n(arst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ser_out(ser_out), .ser_oe(ser_oe), .ser_in(ser_in));
   iopw_load #(.NPIN(4)) i_iopw_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
   //////////////////////////////
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   task ack;
      begin
         @(posedge mclk);
         while (waitrequest !== 1'b0)
            @(posedge mclk);
         rdv = readdata;
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         address <= a;
         writedata <= d;
         write <= 1'b1;
         ack;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge mclk);
         address <= a;
         read <= 1'b1;
         ack;
      end
   endtask
   task count(input integer n);
      begin
         h = 0;
         h1 = 0;
         repeat (n) begin
            @(posedge mclk);
            h = h + (pin_out[0] !== lv);
            h1 = h1 + pin_out[1];
         end
      end
   endtask
   //////////////////////////////
   initial begin
      #50000;
      mismatches = mismatches + 1;
      tally_and_finish;
   end
   initial begin
      cyc(2);
      arst_n <= 1'b1;
      cyc(3);
      chk(pin_out, 4'hA);
      chk(pin_oe_n, 4'hC);
      rd(`IOPW_GEN0_HI);
      chk(rdv, 32'h64);
      rd(8'h9C);
      chk(rdv, 32'h0);
      chk(ser_in, 4'hE);
      ser_out <= 4'h5;
      ser_oe <= 4'h6;
      cyc(2);
      chk(pin_out, 4'h5);
      chk(pin_oe_n, 4'h9);
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h00, {24'h0, ROWS[i*10+2 +: 8]});
         cyc(3);
         rdv = ROWS[i*10 +: 10];
         chk({pin_out[0], pin_oe_n[0]}, rdv[1:0]);
      end
      wr(8'h04, 32'h1);
      for (i = 0; i < 2; i = i + 1) begin
         ext_en <= 4'h2;
         ext_val <= {2'b00, i[0], 1'b0};
         cyc(5);
         rd(`IOPW_STATUS);
         chk(rdv[3:0], {2'b00, i[0], 1'b1});
      end
      wr(`IOPW_GEN0_HI, 32'h2);
      wr(`IOPW_GEN0_LO, 32'h3);
      wr(`IOPW_GEN1_HI, 32'h4);
      wr(`IOPW_GEN1_LO, 32'h1);
      wr(8'h00, 32'h1106);
      cyc(4);
      chk(pin_out[0], 1'b0);
      wr(8'h00, 32'h1406);
      cyc(4);
      chk(pin_out[0], 1'b1);
      rd(`IOPW_STATUS);
      chk(rdv[0], 1'b0);
      wr(8'h04, 32'h2306);
      wr(8'h00, 32'h1306);
      cyc(10);
      lv = 1'b0;
      count(50);
      chk(h, 20);
      chk(h1, 40);
      wr(8'h00, 32'h1006);
      cyc(4);
      lv = pin_out[0];
      count(20);
      chk(h, 0);
      for (i = 0; i < 5; i = i + 1) begin
         wr(8'h00, 32'h1306);
         cyc(i);
         wr(8'h00, 32'h1006);
         cyc(4);
         lv = pin_out[0];
         wr(8'h00, 32'h1206);
         count(30);
         chk(h, lv ? 3 : 2);
         chk(pin_out[0], lv);
         rd(8'h00);
         chk(rdv[10:8], 3'h0);
      end
      arst_n <= 1'b0;
      cyc(2);
      chk(pin_oe_n, 4'hF);
      arst_n <= 1'b1;
      rd(8'h04);
      chk(rdv, 32'h0);
      tally_and_finish;
   end
endmodule // tb
bind iopw_top iopw_chk #(.NPIN(NPIN)) i_iopw_chk (.mclk(mclk),
   .arst_n(arst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .ser_out(ser_out), .ser_oe(ser_oe));
